// ==== cpu_model.sv ====
// CPU-side partner: takes offered interrupts and issues returns.
// Assumes the controller's registered request and vector, all on clk.
`default_nettype none

module cpu_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic take,
  input wire logic [1:0] delay,
  input wire logic ret_now,
  input wire logic irq_req,
  input wire logic [7:0] irq_vector,
  output logic cpu_ack,
  output logic cpu_return,
  output logic [7:0] got_vec
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_r;
  logic [1:0] gap_r;

  // ack before return
  // Gap after an ack, since the request drops only a cycle later
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wait_r <= 2'h0;
      gap_r <= 2'h0;
      cpu_ack <= 1'b0;
      got_vec <= 8'h00;
    end
    else if (gap_r != 2'h0)
    begin
      gap_r <= gap_r - 2'h1;
      cpu_ack <= 1'b0;
    end
    else if (take && irq_req && wait_r == delay)
    begin
      cpu_ack <= 1'b1;
      got_vec <= irq_vector;
      wait_r <= 2'h0;
      gap_r <= 2'h3;
    end
    else if (take && irq_req)
      wait_r <= wait_r + 2'h1;
    else
      wait_r <= 2'h0;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cpu_return <= 1'b0;
    else
      cpu_return <= ret_now;
  end
endmodule : cpu_model

`default_nettype wire

// ==== irq_consts.svh ====
// Offsets, field positions, reset values and vectors of the interrupt block.
// Assumes inclusion by bare name from the controller and its testbench.
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH

`define REG_IRQ_EN 4'h0
`define REG_IRQ_PRIO 4'h1
`define REG_EXT_EN 4'h2
`define REG_EXT_PRIO 4'h3
`define REG_CTL 4'h4
`define REG_FLAGS 4'h5
`define REG_SVC 4'h6
`define REG_EVT 4'h7
`define REG_EVT_MASK 4'h8

`define RST_BYTE 8'h00
`define GATE_BIT 7
`define CTL_EXT0_EDGE 0
`define CTL_EXT1_EDGE 1
`define CTL_PF_EN 2
`define FLG_EXT0 0
`define FLG_TF0 1
`define FLG_EXT1 2
`define FLG_TF1 3

`define EVT_DISPATCH 0
`define EVT_PF_ENTRY 1
`define EVT_NESTED 2
`define EVT_BAD_RETURN 3

`define IDX_PF 4'h0
`define IDX_EXT0 4'h1
`define IDX_TF0 4'h2
`define IDX_EXT1 4'h3
`define IDX_TF1 4'h4
`define IDX_SHARED 4'h8

`define VEC_PF 8'h33
`define VEC_EXT0 8'h03
`define VEC_TF0 8'h0B
`define VEC_EXT1 8'h13
`define VEC_TF1 8'h1B
`define VEC_SER0 8'h23
`define VEC_TF2 8'h2B
`define VEC_SER1 8'h3B
`define VEC_SHARED 8'h43
`define VEC_TF3 8'h4B
`define VEC_SER2 8'h53
`define VEC_WP 8'h5B
`define VEC_CAN 8'h6B
`define VEC_ETH 8'h73
`define VEC_WDT 8'h63
`define VEC_EPM 8'h7B

`endif

// ==== irq_pkg.sv ====
// Types shared by the interrupt resolver and the controller top.
// Assumes irq_consts.svh is on the include path.
`default_nettype none

package irq_pkg;
  // Service level, ordered so that a larger code preempts a smaller one
  typedef enum logic [1:0] {
    LVL_NONE = 2'h0,
    LVL_LOW = 2'h1,
    LVL_HIGH = 2'h2,
    LVL_PF = 2'h3
  } level_t;
endpackage : irq_pkg

`default_nettype wire

// ==== irq_resolver.sv ====
// Picks the winning request among sixteen by level and natural priority.
// Assumes request bit 0 is the power-fail source; purely combinational.
`default_nettype none

module irq_resolver #(
  parameter int N = 16
) (
  input wire logic [N-1:0] req,
  input wire logic [N-1:0] prio_hi,
  output logic found,
  output logic [3:0] idx,
  output irq_pkg::level_t level
);

  // Lowest set bit wins; used for both the high and the low group
  function automatic logic [4:0] lowest(input logic [N-1:0] v);
    logic [4:0] r;
    r = 5'h10;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (v[i])
        r = 5'(i);
    end
    return r;
  endfunction : lowest

  logic [N-1:0] hi_req;
  logic [N-1:0] lo_req;
  logic [4:0] hi_pick;
  logic [4:0] lo_pick;

  assign hi_req = req & prio_hi & ~{{(N-1){1'b0}}, 1'b1};
  assign lo_req = req & ~prio_hi & ~{{(N-1){1'b0}}, 1'b1};
  assign hi_pick = lowest(hi_req);
  assign lo_pick = lowest(lo_req);

  always_comb
  begin
    found = 1'b1;
    idx = 4'h0;
    level = irq_pkg::LVL_PF;
    if (req[0])
    begin
      idx = 4'h0;
      level = irq_pkg::LVL_PF;
    end
    else if (!hi_pick[4])
    begin
      idx = hi_pick[3:0];
      level = irq_pkg::LVL_HIGH;
    end
    else if (!lo_pick[4])
    begin
      idx = lo_pick[3:0];
      level = irq_pkg::LVL_LOW;
    end
    else
    begin
      found = 1'b0;
      level = irq_pkg::LVL_NONE;
    end
  end

endmodule : irq_resolver

`default_nettype wire

// ==== priority_interrupt_controller.sv ====
// Sixteen-source interrupt controller with three service levels.
// Assumes peripheral flags are on clk; the two external pins are not.
//
// Behaviour
// RULE1 - Sixteen sources arbitrated over three levels: low, high, highest.
// RULE2 - Non power-fail sources need own enable and global gate both set.
// RULE3 - Highest level only for power-fail; ignores gate, vector 33h.
// RULE4 - Per-source priority bit: one means high, zero means low.
// RULE5 - Same level ties go to lowest natural number, power-fail zero.
// RULE6 - Each source has a fixed vector and fixed enable/priority bits.
// RULE7 - External 2 to 5 and single-wire master share line 8, 43h.
// RULE8 - Single-wire master request replaces external 5 while enabled.
// RULE9 - Timer 0 and 1 flags clear on entry to their routine.
// RULE10 - External 0/1: edge flag clears on entry, level flag tracks pin.
// RULE11 - Software clears every flag not cleared by hardware.
// RULE12 - Single-wire enables and flags live inside that master, indirect.
// RULE13 - Watchdog vectors to 63h only with its enable and global gate.
// RULE14 - Only a strictly higher level preempts; level drops on return.
`default_nettype none
`include "irq_consts.svh"

module priority_interrupt_controller (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic power_fail_request,
  input wire logic ext0_pin_n,
  input wire logic ext1_pin_n,
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic serial0_flag,
  input wire logic timer2_flag,
  input wire logic serial1_flag,
  input wire logic [3:0] ext_flag_reg,
  input wire logic onewire_master_request,
  input wire logic onewire_master_irq_en,
  input wire logic timer3_flag,
  input wire logic serial2_flag,
  input wire logic write_protect_flag,
  input wire logic can_flag,
  input wire logic eth_activity_flag,
  input wire logic watchdog_expiry_flag,
  input wire logic eth_power_flag,
  input wire logic cpu_ack,
  input wire logic cpu_return,
  output logic irq_req,
  output logic [7:0] irq_vector,
  output logic [3:0] irq_index,
  output logic [1:0] irq_level,
  output logic [2:0] svc_active,
  output logic ext0_pending_flag,
  output logic ext1_pending_flag,
  output logic timer0_overflow_flag,
  output logic timer1_overflow_flag,
  output logic evt_irq
);

  localparam int NSRC = 16;

  function automatic logic [7:0] vector_of(input logic [3:0] i);
    logic [7:0] v;
    v = `VEC_PF;
    unique case (i)
      4'h0: v = `VEC_PF;
      4'h1: v = `VEC_EXT0;
      4'h2: v = `VEC_TF0;
      4'h3: v = `VEC_EXT1;
      4'h4: v = `VEC_TF1;
      4'h5: v = `VEC_SER0;
      4'h6: v = `VEC_TF2;
      4'h7: v = `VEC_SER1;
      4'h8: v = `VEC_SHARED;
      4'h9: v = `VEC_TF3;
      4'hA: v = `VEC_SER2;
      4'hB: v = `VEC_WP;
      4'hC: v = `VEC_CAN;
      4'hD: v = `VEC_ETH;
      4'hE: v = `VEC_WDT;
      4'hF: v = `VEC_EPM;
    endcase
    return v;
  endfunction : vector_of

  // Maps one control byte pair onto natural-priority order
  function automatic logic [NSRC-1:0] by_source(input logic [7:0] lo,
                                                input logic [7:0] hi);
    return {hi[7], hi[4], hi[5], hi[6], hi[3], hi[2], hi[1], hi[0],
            lo[6], lo[5], lo[4], lo[3], lo[2], lo[1], lo[0], 1'b0};
  endfunction : by_source

  logic [7:0] irq_enable_reg_r;
  logic [7:0] irq_priority_reg_r;
  logic [7:0] ext_irq_enable_reg_r;
  logic [7:0] ext_irq_priority_reg_r;
  logic [7:0] ctl_r;
  logic [3:0] evt_r;
  logic [3:0] evt_mask_r;
  logic [2:0] svc_r;
  logic [2:0] ext_sync0_r;
  logic [2:0] ext_sync1_r;
  logic req_r;
  logic [7:0] vec_r;
  logic [3:0] idx_r;
  irq_pkg::level_t lvl_r;
  logic [7:0] rdata_r;
  logic ext0_flag_r;
  logic ext1_flag_r;
  logic tf0_flag_r;
  logic tf1_flag_r;

  logic global_irq_gate;
  logic power_fail_request_en;
  logic ext0_edge_mode;
  logic ext1_edge_mode;
  logic shared_line;
  logic [NSRC-1:0] flags;
  logic [NSRC-1:0] enables;
  logic [NSRC-1:0] prio_hi;
  logic [NSRC-1:0] pending;
  logic res_found;
  logic [3:0] res_idx;
  irq_pkg::level_t res_lvl;
  irq_pkg::level_t cur_lvl;
  logic take;
  logic ack;
  logic wr_flags;
  logic [3:0] evt_set;

  assign global_irq_gate = irq_enable_reg_r[`GATE_BIT];
  assign power_fail_request_en = ctl_r[`CTL_PF_EN];
  assign ext0_edge_mode = ctl_r[`CTL_EXT0_EDGE];
  assign ext1_edge_mode = ctl_r[`CTL_EXT1_EDGE];
  assign ack = cpu_ack && req_r;
  assign wr_flags = reg_wr && reg_addr == `REG_FLAGS;

  // RULE12 enable held outside
  // RULE8 single-wire mux
  // RULE7 shared line eight
  assign shared_line = |ext_flag_reg[2:0]
    | (onewire_master_irq_en ? onewire_master_request : ext_flag_reg[3]);

  assign flags = {eth_power_flag, watchdog_expiry_flag, eth_activity_flag,
                  can_flag, write_protect_flag, serial2_flag, timer3_flag,
                  shared_line, serial1_flag, timer2_flag, serial0_flag,
                  tf1_flag_r, ext1_flag_r, tf0_flag_r, ext0_flag_r,
                  power_fail_request};

  // RULE6 enable bit positions
  // RULE13 watchdog enable and gate
  assign enables = by_source(irq_enable_reg_r, ext_irq_enable_reg_r);
  assign prio_hi = by_source(irq_priority_reg_r, ext_irq_priority_reg_r);

  // RULE2 gate in series
  // RULE3 power-fail bypasses gate
  assign pending = {flags[NSRC-1:1] & enables[NSRC-1:1]
                      & {(NSRC-1){global_irq_gate}},
                    flags[0] & power_fail_request_en};

  // RULE1 three-level arbitration
  // RULE4 priority bit selects level
  // RULE5 natural order tie-break
  irq_resolver #(
    .N(NSRC)
  ) u_resolver (
    .req(pending),
    .prio_hi(prio_hi),
    .found(res_found),
    .idx(res_idx),
    .level(res_lvl)
  );

  always_comb
  begin
    cur_lvl = irq_pkg::LVL_NONE;
    if (svc_r[2])
      cur_lvl = irq_pkg::LVL_PF;
    else if (svc_r[1])
      cur_lvl = irq_pkg::LVL_HIGH;
    else if (svc_r[0])
      cur_lvl = irq_pkg::LVL_LOW;
  end

  // RULE14 strictly higher only
  assign take = res_found && (res_lvl > cur_lvl);

  // Offer is withdrawn the cycle after the ack so a stale winner is never repeated
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      req_r <= 1'b0;
      vec_r <= `RST_BYTE;
      idx_r <= 4'h0;
      lvl_r <= irq_pkg::LVL_NONE;
    end
    else
    begin
      req_r <= take && !ack;
      // RULE6 fixed vector table
      vec_r <= vector_of(res_idx);
      idx_r <= res_idx;
      lvl_r <= res_lvl;
    end
  end

  // RULE14 level stack
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      svc_r <= 3'h0;
    else if (ack)
      svc_r <= svc_r | (3'h1 << (2'(lvl_r) - 2'h1));
    else if (cpu_return)
    begin
      if (svc_r[2])
        svc_r[2] <= 1'b0;
      else if (svc_r[1])
        svc_r[1] <= 1'b0;
      else
        svc_r[0] <= 1'b0;
    end
  end

  // Pins are asynchronous; stage 0 feeds only stage 1
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ext_sync0_r <= 3'h7;
      ext_sync1_r <= 3'h7;
    end
    else
    begin
      ext_sync0_r <= {ext_sync0_r[1:0], ext0_pin_n};
      ext_sync1_r <= {ext_sync1_r[1:0], ext1_pin_n};
    end
  end

  // RULE10 external zero flag
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ext0_flag_r <= 1'b0;
    else if (!ext0_edge_mode)
      ext0_flag_r <= !ext_sync0_r[1];
    else if (ext_sync0_r[2] && !ext_sync0_r[1])
      ext0_flag_r <= 1'b1;
    else if ((ack && idx_r == `IDX_EXT0)
             || (wr_flags && reg_wdata[`FLG_EXT0]))
      ext0_flag_r <= 1'b0;
  end

  // RULE10 external one flag
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ext1_flag_r <= 1'b0;
    else if (!ext1_edge_mode)
      ext1_flag_r <= !ext_sync1_r[1];
    else if (ext_sync1_r[2] && !ext_sync1_r[1])
      ext1_flag_r <= 1'b1;
    else if ((ack && idx_r == `IDX_EXT1)
             || (wr_flags && reg_wdata[`FLG_EXT1]))
      ext1_flag_r <= 1'b0;
  end

  // RULE9 timer flags auto-clear
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tf0_flag_r <= 1'b0;
      tf1_flag_r <= 1'b0;
    end
    else
    begin
      if (timer0_overflow)
        tf0_flag_r <= 1'b1;
      else if ((ack && idx_r == `IDX_TF0)
               || (wr_flags && reg_wdata[`FLG_TF0]))
        tf0_flag_r <= 1'b0;
      if (timer1_overflow)
        tf1_flag_r <= 1'b1;
      else if ((ack && idx_r == `IDX_TF1)
               || (wr_flags && reg_wdata[`FLG_TF1]))
        tf1_flag_r <= 1'b0;
    end
  end

  // Control registers; reset leaves every source disabled
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_enable_reg_r <= `RST_BYTE;
      irq_priority_reg_r <= `RST_BYTE;
      ext_irq_enable_reg_r <= `RST_BYTE;
      ext_irq_priority_reg_r <= `RST_BYTE;
      ctl_r <= `RST_BYTE;
      evt_mask_r <= 4'h0;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        `REG_IRQ_EN: irq_enable_reg_r <= reg_wdata;
        `REG_IRQ_PRIO: irq_priority_reg_r <= reg_wdata;
        `REG_EXT_EN: ext_irq_enable_reg_r <= reg_wdata;
        `REG_EXT_PRIO: ext_irq_priority_reg_r <= reg_wdata;
        `REG_CTL: ctl_r <= reg_wdata;
        `REG_EVT_MASK: evt_mask_r <= reg_wdata[3:0];
        default: ;
      endcase
    end
  end

  always_comb
  begin
    evt_set = 4'h0;
    evt_set[`EVT_DISPATCH] = ack;
    evt_set[`EVT_PF_ENTRY] = ack && lvl_r == irq_pkg::LVL_PF;
    evt_set[`EVT_NESTED] = ack && svc_r != 3'h0;
    evt_set[`EVT_BAD_RETURN] = cpu_return && svc_r == 3'h0;
  end

  // A new event in the read-clear cycle survives the clear
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      evt_r <= 4'h0;
    else if (reg_rd && reg_addr == `REG_EVT)
      evt_r <= evt_set;
    else
      evt_r <= evt_r | evt_set;
  end

  // Read data stand for exactly one cycle after the strobe
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata_r <= `RST_BYTE;
    else if (!reg_rd)
      rdata_r <= `RST_BYTE;
    else
    begin
      unique case (reg_addr)
        `REG_IRQ_EN: rdata_r <= irq_enable_reg_r;
        `REG_IRQ_PRIO: rdata_r <= irq_priority_reg_r;
        `REG_EXT_EN: rdata_r <= ext_irq_enable_reg_r;
        `REG_EXT_PRIO: rdata_r <= ext_irq_priority_reg_r;
        `REG_CTL: rdata_r <= ctl_r;
        `REG_FLAGS: rdata_r <= {4'h0, tf1_flag_r, ext1_flag_r, tf0_flag_r,
                                ext0_flag_r};
        `REG_SVC: rdata_r <= {idx_r, 1'b0, svc_r};
        `REG_EVT: rdata_r <= {4'h0, evt_r};
        `REG_EVT_MASK: rdata_r <= {4'h0, evt_mask_r};
        default: rdata_r <= `RST_BYTE;
      endcase
    end
  end

  assign reg_rdata = rdata_r;
  assign irq_req = req_r;
  assign irq_vector = vec_r;
  assign irq_index = idx_r;
  assign irq_level = 2'(lvl_r);
  assign svc_active = svc_r;
  assign ext0_pending_flag = ext0_flag_r;
  assign ext1_pending_flag = ext1_flag_r;
  assign timer0_overflow_flag = tf0_flag_r;
  assign timer1_overflow_flag = tf1_flag_r;
  assign evt_irq = |(evt_r & evt_mask_r);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence tf0_entry_s;
    ack && idx_r == `IDX_TF0 && !timer0_overflow;
  endsequence

  sequence ext0_edge_entry_s;
    ack && idx_r == `IDX_EXT0 && ext0_edge_mode
      && !(ext_sync0_r[2] && !ext_sync0_r[1]);
  endsequence

  gate_blocks_a: assert property ( // RULE2
    req_r && idx_r != `IDX_PF |-> $past(global_irq_gate))
    else $error("request offered while global gate was clear");

  pf_vector_a: assert property ( // RULE3
    power_fail_request && power_fail_request_en && !svc_r[2] && !ack
      |=> req_r && vec_r == `VEC_PF && lvl_r == irq_pkg::LVL_PF)
    else $error("power-fail not offered at top level");

  prio_level_a: assert property ( // RULE4
    req_r && idx_r != `IDX_PF |->
      lvl_r == ($past(prio_hi[res_idx]) ? irq_pkg::LVL_HIGH
                                        : irq_pkg::LVL_LOW))
    else $error("level disagrees with priority bit");

  natural_order_a: assert property ( // RULE5
    req_r && idx_r != `IDX_PF |->
      ($past(pending & (prio_hi ^ {NSRC{res_lvl == irq_pkg::LVL_LOW}}))
        & ((16'h0001 << idx_r) - 16'h0001)) == 16'h0000)
    else $error("lower natural number at same level was skipped");

  shared_mux_a: assert property ( // RULE8
    onewire_master_irq_en && !onewire_master_request
      && ext_flag_reg[2:0] == 3'h0 |-> !shared_line)
    else $error("external five passed while single-wire enabled");

  timer_clear_a: assert property ( // RULE9
    tf0_entry_s |=> !tf0_flag_r)
    else $error("timer 0 flag survived entry");

  ext_edge_clear_a: assert property ( // RULE10
    ext0_edge_entry_s ##1 ext0_edge_mode |-> !ext0_flag_r)
    else $error("edge flag survived entry");

  ext_level_a: assert property ( // RULE10
    !ext0_edge_mode ##1 !ext0_edge_mode
      |-> ext0_flag_r == !$past(ext_sync0_r[1]))
    else $error("level flag does not track pin");

  no_preempt_a: assert property ( // RULE14
    req_r |-> lvl_r > $past(cur_lvl))
    else $error("offer not above level in service");

  return_level_a: assert property ( // RULE14
    cpu_return && !ack && svc_r[2]
      |=> !svc_r[2] && svc_r[1:0] == $past(svc_r[1:0]))
    else $error("power-fail level kept after return");

endmodule : priority_interrupt_controller

`default_nettype wire

// ==== priority_interrupt_controller_tb.sv ====
// Self-checking bench: random arbitration against a model, then service.
// Assumes irq_consts.svh on the include path and cpu_model as partner.
`default_nettype none
`include "irq_consts.svh"

module priority_interrupt_controller_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, reg_wr, reg_rd, x0n, x1n, t0o, t1o, ack, ret;
  logic irq_req, f0, f1, ft0, ft1, evt_irq, take, ret_now, ow_en, ow_req;
  logic [3:0] reg_addr, xf, irq_index;
  logic [7:0] reg_wdata, reg_rdata, irq_vector, got_vec, d;
  logic [7:0] ie, ip, ext_irq_enable_reg, ext_irq_priority_reg, ctl;
  logic [15:0] s, src;
  logic [1:0] irq_level, dly;
  logic [2:0] svc;
  int num_errors, check_count, best, lvl;
  localparam logic [7:0] vec_tab [16] = '{8'h33, 8'h03, 8'h0B, 8'h13,
    8'h1B, 8'h23, 8'h2B, 8'h3B, 8'h43, 8'h4B, 8'h53, 8'h5B, 8'h6B, 8'h73,
    8'h63, 8'h7B};
  localparam int emap [8] = '{0, 1, 2, 3, 6, 5, 4, 7};

  priority_interrupt_controller priority_interrupt_controller_inst (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .power_fail_request(src[0]), .ext0_pin_n(x0n), .ext1_pin_n(x1n),
    .timer0_overflow(t0o), .timer1_overflow(t1o), .serial0_flag(src[5]),
    .timer2_flag(src[6]), .serial1_flag(src[7]), .ext_flag_reg(xf),
    .onewire_master_request(ow_req), .onewire_master_irq_en(ow_en),
    .timer3_flag(src[9]), .serial2_flag(src[10]),
    .write_protect_flag(src[11]), .can_flag(src[12]),
    .eth_activity_flag(src[13]), .watchdog_expiry_flag(src[14]),
    .eth_power_flag(src[15]), .cpu_ack(ack), .cpu_return(ret),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_index(irq_index),
    .irq_level(irq_level), .svc_active(svc), .ext0_pending_flag(f0),
    .ext1_pending_flag(f1), .timer0_overflow_flag(ft0),
    .timer1_overflow_flag(ft1), .evt_irq(evt_irq));

  cpu_model cpu_model_inst (.clk(clk), .nrst(nrst), .take(take),
    .delay(dly), .ret_now(ret_now), .irq_req(irq_req),
    .irq_vector(irq_vector), .cpu_ack(ack), .cpu_return(ret),
    .got_vec(got_vec));

  task automatic end_sim;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1)
    begin
      $display("MISMATCH %0t %s", $time, m);
      num_errors++;
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic wait_ack;
    int n;
    n = 0;
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    chk(n < 20, "no acknowledge");
    repeat (3) @(posedge clk);
    #1;
  endtask : wait_ack

  task automatic do_ret;
    @(posedge clk);
    ret_now <= 1'b1;
    @(posedge clk);
    ret_now <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : do_ret

  // Winner: highest level, then lowest natural number
  task automatic model;
    logic e, h;
    best = -1;
    lvl = 0;
    if (s[0] && ctl[2])
    begin
      best = 0;
      lvl = 3;
    end
    for (int i = 15; i >= 1; i--)
    begin
      e = (i < 8) ? ie[i-1] : ext_irq_enable_reg[emap[i-8]];
      h = (i < 8) ? ip[i-1] : ext_irq_priority_reg[emap[i-8]];
      if (s[i] && e && ie[7] && lvl < 3 && (h ? 2 : 1) >= lvl)
      begin
        best = i;
        lvl = h ? 2 : 1;
      end
    end
  endtask : model

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Span well above the whole sequence
  initial
  begin
    #(20000 * 50);
    num_errors++;
    end_sim;
  end

  initial
  begin
    {nrst, reg_wr, reg_rd, t0o, t1o, take, ret_now, ow_en, ow_req} = '0;
    {x0n, x1n} = 2'b11;
    {reg_addr, xf, reg_wdata, src} = '0;
    num_errors = 0;
    check_count = 0;
    void'($urandom(32'h0920));
    dly = 2'($urandom);
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    #1 chk(irq_req === 1'b0 && svc === 3'h0, "reset outputs");
    for (int a = 0; a < 9; a++)
    begin
      rd(4'(a), d);
      chk(d === 8'h00, "reset value");
    end
    wr(4'hA, 8'hFF);
    rd(4'hA, d);
    chk(d === 8'h00, "unmapped read");
    repeat (60)
    begin
      {ie, ip, ext_irq_enable_reg, ext_irq_priority_reg} = 32'($urandom);
      ctl = 8'($urandom) & 8'h04;
      wr(`REG_IRQ_EN, ie);
      wr(`REG_IRQ_PRIO, ip);
      wr(`REG_EXT_EN, ext_irq_enable_reg);
      wr(`REG_EXT_PRIO, ext_irq_priority_reg);
      wr(`REG_CTL, ctl);
      s = 16'($urandom) & 16'hFFE1;
      d = 8'($urandom);
      // enable held in the single-wire master
      ow_en <= d[4];
      ow_req <= d[5];
      xf <= d[3:0];
      s[8] = |d[2:0] | (d[4] ? d[5] : d[3]);
      src <= s;
      repeat (3) @(posedge clk);
      #1 model;
      chk(irq_req === (best >= 0), "request");
      if (best >= 0)
      begin
        chk(irq_vector === vec_tab[best], "vector");
        chk(irq_index === 4'(best), "index");
        chk(irq_level === 2'(lvl), "level");
      end
      rd(`REG_IRQ_PRIO, d);
      chk(d === ip, "priority readback");
    end
    // Directed service and nesting
    src <= '0;
    xf <= '0;
    ow_req <= 1'b0;
    wr(`REG_IRQ_EN, 8'h81);
    wr(`REG_CTL, 8'h01);
    x0n <= 1'b0;
    repeat (2) @(posedge clk);
    x0n <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk(f0 === 1'b1, "edge latch");
    take <= 1'b1;
    wait_ack;
    chk(f0 === 1'b0 && got_vec === 8'h03, "edge entry");
    take <= 1'b0;
    do_ret;
    wr(`REG_CTL, 8'h00);
    {x0n, x1n} <= 2'b00;
    repeat (6) @(posedge clk);
    #1 chk(f0 === 1'b1 && f1 === 1'b1, "level low");
    {x0n, x1n} <= 2'b11;
    repeat (6) @(posedge clk);
    #1 chk(f0 === 1'b0 && f1 === 1'b0, "level high");
    rd(`REG_EVT, d);
    wr(`REG_IRQ_PRIO, 8'h00);
    wr(`REG_IRQ_EN, 8'h8A);
    take <= 1'b1;
    t0o <= 1'b1;
    @(posedge clk);
    t0o <= 1'b0;
    wait_ack;
    chk(ft0 === 1'b0 && got_vec === 8'h0B, "timer0 entry");
    chk(svc === 3'b001, "low in service");
    t1o <= 1'b1;
    @(posedge clk);
    t1o <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk(ft1 === 1'b1 && irq_req === 1'b0, "no equal nest");
    wr(`REG_IRQ_PRIO, 8'h08);
    wait_ack;
    chk(ft1 === 1'b0 && got_vec === 8'h1B, "timer1 entry");
    chk(svc === 3'b011, "high nests");
    wr(`REG_CTL, 8'h04);
    wr(`REG_IRQ_EN, 8'h00);
    src <= 16'h0001;
    wait_ack;
    chk(got_vec === 8'h33 && svc === 3'b111, "power fail");
    src <= '0;
    do_ret;
    chk(svc === 3'b011, "pop top");
    do_ret;
    chk(svc === 3'b001, "pop high");
    do_ret;
    chk(svc === 3'b000, "pop low");
    do_ret;
    chk(evt_irq === 1'b0, "masked event");
    wr(`REG_EVT_MASK, 8'h08);
    repeat (2) @(posedge clk);
    #1 chk(evt_irq === 1'b1, "event raised");
    rd(`REG_EVT, d);
    chk(d === 8'h0F && evt_irq === 1'b0, "event read clears");
    // software clears a flag with no service entry
    t0o <= 1'b1;
    @(posedge clk);
    t0o <= 1'b0;
    rd(`REG_FLAGS, d);
    chk(d === 8'h02 && ft0 === 1'b1, "flag set");
    wr(`REG_FLAGS, 8'h02);
    rd(`REG_FLAGS, d);
    chk(d === 8'h00 && ft0 === 1'b0, "software clear");
    end_sim;
  end
endmodule : priority_interrupt_controller_tb

`default_nettype wire
